/* ssr_top.sv */
// stop-mode, clock-mode and reset-pin sequencer with APB registers
`timescale 1ns/100ps
module ssr_top
    import ssr_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = LOCK_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        stop_req,
    input  wire logic        wait_req,
    input  wire logic        irq_req,
    input  wire logic        reset_event,
    input  wire logic        osc_qual_i,
    input  wire logic        osc_present_i,
    input  wire logic        osc_slow_i,
    input  wire logic        reset_pin_i,
    output logic             reset_pin_o,
    output logic             reset_pin_oe_n,
    output logic             sys_reset_active,
    output logic             reset_ext_src,
    output logic             clock_monitor_reset,
    output logic             vreg_low_power,
    output logic             api_enable,
    output logic             pll_enable,
    output logic             pll_locked,
    output logic [4:0]       post_divider_setting,
    output logic             irc_enable,
    output logic             xosc_enable,
    output logic             pll_reference_clock_enable,
    output logic             pll_reference_clock_src_osc,
    output logic             busclk_enable,
    output logic             busclk_src_osc,
    output logic             oscillator_qualified,
    output logic [1:0]       clock_mode,
    output logic             stop_active,
    output logic             pseudo_stop_active,
    output logic             wait_active
);
    // ***************************************************
    // declarations
    // ***************************************************
    ssr_stop_e   st_q;
    ssr_rst_e    rs_q;
    logic [3:0]  meta_q;
    logic [3:0]  sync_q;
    logic        pseudo_stop_select_q;
    logic        oscillator_enable_q;
    logic        psel_q;
    logic        woff_q;
    logic [4:0]  post_divider_setting_q;
    logic [4:0]  pll_div_q;
    logic        pseudo_q;
    logic        ext_q;
    logic        cm_q;
    logic        qual_prev_q;
    logic        running;
    logic        cm_fail;
    logic        qual_lost;
    logic        rec_done;
    logic        drv_done;
    logic        set_done;
    logic        wr_en;
    logic        rd_setup;
    logic        hit;
    logic [31:0] rd_mux;
    logic [9:0]  drive_cnt_q;

    // ***************************************************
    // pin synchronisers
    // ***************************************************
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            meta_q <= SYNC_RST;
            sync_q <= SYNC_RST;
        end else begin
            meta_q <= {reset_pin_i, osc_slow_i, osc_present_i, osc_qual_i};
            sync_q <= meta_q;
        end
    end

    // ***************************************************
    // APB slave
    // ***************************************************
    // zero wait states: read data is captured in the setup cycle
    assign pready   = 1'b1;
    assign wr_en    = psel && penable && pwrite && hit;
    assign rd_setup = psel && !penable && !pwrite;
    assign pslverr  = psel && penable && !hit;

    always_comb begin
        hit    = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            CTRL_OFF:    rd_mux[3:0] = {woff_q, psel_q, oscillator_enable_q, pseudo_stop_select_q};
            POST_DIVIDER_SETTING_OFF: rd_mux[4:0] = post_divider_setting_q;
            STATUS_OFF: begin
                rd_mux[ST_LOCK]           = pll_locked;
                rd_mux[ST_QUAL]           = oscillator_qualified;
                rd_mux[ST_STOP]           = stop_active;
                rd_mux[ST_PSEUDO_STOP_SELECT]           = pseudo_stop_active;
                rd_mux[ST_EXT]            = ext_q;
                rd_mux[ST_MODE+1:ST_MODE] = clock_mode;
            end
            default: hit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    // ***************************************************
    // control registers
    // ***************************************************
    assign qual_lost = qual_prev_q && !oscillator_qualified
                     && st_q == SS_RUN;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            {woff_q, psel_q, oscillator_enable_q, pseudo_stop_select_q} <= CTRL_RST;
        end else begin
            if (wr_en && paddr == CTRL_OFF) begin
                pseudo_stop_select_q <= pwdata[CTRL_PSEUDO_STOP_SELECT];
                oscillator_enable_q <= pwdata[CTRL_OSCILLATOR_ENABLE];
                psel_q <= pwdata[CTRL_PSEL];
                woff_q <= pwdata[CTRL_WOFF];
            end
            if (qual_lost && oscillator_enable_q && !psel_q) begin
                psel_q <= 1'b1;
            end
            if (cm_q) begin
                oscillator_enable_q <= 1'b0;
                psel_q <= 1'b1;
            end
        end
    end

    // divider is frozen while the bus runs from the oscillator
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            post_divider_setting_q <= POST_DIVIDER_SETTING_RST;
        end else if (wr_en && paddr == POST_DIVIDER_SETTING_OFF && psel_q) begin
            post_divider_setting_q <= pwdata[4:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pll_div_q <= POST_DIVIDER_SETTING_UNLK;
        end else begin
            pll_div_q <= pll_locked ? post_divider_setting_q : POST_DIVIDER_SETTING_UNLK;
        end
    end
    assign post_divider_setting = pll_div_q;

    // ***************************************************
    // stop sequence
    // ***************************************************
    ssr_delay #(
        .COUNT (RECOVERY_CYC)
    ) u_recov (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (st_q == SS_RECOV),
        .done     (rec_done)
    );

    ssr_delay #(
        .COUNT (LOCK_CYCLES)
    ) u_lock (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (pll_enable),
        .done     (pll_locked)
    );

    // power-on starts with the PLL locking, bus on the unlocked divider
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            st_q     <= SS_RELOCK;
            pseudo_q <= 1'b0;
        end else begin
            case (st_q)
                SS_RUN: begin
                    if (stop_req && !sys_reset_active) begin
                        st_q <= SS_STOP;
                        pseudo_q <= pseudo_stop_select_q && oscillator_enable_q;
                    end
                end
                SS_STOP: begin
                    if (irq_req) begin
                        st_q <= SS_RECOV;
                    end
                end
                SS_RECOV: begin
                    if (rec_done) begin
                        st_q <= SS_RELOCK;
                    end
                end
                SS_RELOCK: begin
                    if (pll_locked) begin
                        st_q <= SS_RUN;
                    end
                end
                default: st_q <= SS_RUN;
            endcase
        end
    end

    // ***************************************************
    // clock gating outputs
    // ***************************************************
    assign running            = st_q == SS_RUN || st_q == SS_RELOCK;
    assign stop_active        = st_q == SS_STOP;
    assign pseudo_stop_active = stop_active && pseudo_q;
    assign wait_active        = wait_req && st_q == SS_RUN;
    assign vreg_low_power     = stop_active;
    assign api_enable         = 1'b1;
    assign pll_enable         = running && !(wait_active && woff_q);
    assign irc_enable         = !stop_active;
    assign xosc_enable        = stop_active ? pseudo_q : oscillator_enable_q;
    assign pll_reference_clock_enable      = !stop_active;
    assign pll_reference_clock_src_osc     = oscillator_enable_q;
    assign busclk_enable      = running;
    assign oscillator_qualified = sync_q[SY_QUAL] && pll_locked && oscillator_enable_q;
    assign busclk_src_osc     = oscillator_enable_q && !psel_q && oscillator_qualified;

    always_comb begin
        if (!oscillator_enable_q) begin
            clock_mode = MODE_INT_REF;
        end else if (psel_q) begin
            clock_mode = MODE_EXT_REF;
        end else begin
            clock_mode = MODE_BYPASS;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            qual_prev_q <= 1'b0;
        end else begin
            qual_prev_q <= oscillator_qualified;
        end
    end

    // ***************************************************
    // clock monitor and reset pin
    // ***************************************************
    // the slow input flags oscillation under CM_FAIL_KHZ
    // monitor only in run
    assign cm_fail = oscillator_enable_q && st_q == SS_RUN
                   && (!sync_q[SY_PRES] || sync_q[SY_SLOW]);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cm_q <= 1'b0;
        end else begin
            cm_q <= cm_fail && rs_q == RS_IDLE && !cm_q;
        end
    end
    assign clock_monitor_reset = cm_q;

    ssr_delay #(
        .COUNT (RST_DRIVE_CYC)
    ) u_drive (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (rs_q == RS_DRIVE),
        .done     (drv_done)
    );

    ssr_delay #(
        .COUNT (RST_SETTLE_CYC)
    ) u_settle (
        .core_clk (core_clk),
        .rstn     (rstn),
        .run      (rs_q == RS_SETTLE),
        .done     (set_done)
    );

    // a pin held low from outside restarts the sequence each time
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rs_q  <= RS_IDLE;
            ext_q <= 1'b0;
        end else begin
            case (rs_q)
                RS_IDLE: begin
                    if (reset_event || cm_q || !sync_q[SY_PIN]) begin
                        rs_q <= RS_DRIVE;
                    end
                end
                RS_DRIVE: begin
                    if (drv_done) begin
                        rs_q <= RS_SETTLE;
                    end
                end
                RS_SETTLE: begin
                    if (set_done) begin
                        rs_q  <= RS_IDLE;
                        ext_q <= !sync_q[SY_PIN];
                    end
                end
                default: rs_q <= RS_IDLE;
            endcase
        end
    end

    assign reset_pin_o      = 1'b0;
    assign reset_pin_oe_n   = rs_q != RS_DRIVE;
    assign sys_reset_active = rs_q != RS_IDLE;
    assign reset_ext_src    = ext_q;

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    always_ff @(posedge core_clk) begin
        if (!rstn || reset_pin_oe_n) begin
            drive_cnt_q <= 10'h000;
        end else begin
            drive_cnt_q <= drive_cnt_q + 10'h001;
        end
    end

    property p_wait_clk;
        wait_active && !woff_q |-> pll_enable && busclk_enable;
    endproperty
    a_wait_clk: assert property (p_wait_clk)
        else $error("wait mode stopped a clock");

    property p_stop_cause;
        $rose(stop_active) |-> $past(stop_req);
    endproperty
    a_stop_cause: assert property (p_stop_cause)
        else $error("stop entered without stop request");

    property p_stop_off;
        stop_active |-> !pll_enable && !irc_enable && vreg_low_power
                        && api_enable && !busclk_enable;
    endproperty
    a_stop_off: assert property (p_stop_off)
        else $error("stop left PLL, RC or bus clock on");

    property p_pseudo;
        st_q == SS_RUN && stop_req && !sys_reset_active |=>
            pseudo_stop_active == ($past(pseudo_stop_select_q) && $past(oscillator_enable_q));
    endproperty
    a_pseudo: assert property (p_pseudo)
        else $error("wrong stop flavour selected");

    property p_wake;
        stop_active && irq_req |=> st_q == SS_RECOV ##1 !stop_active;
    endproperty
    a_wake: assert property (p_wake)
        else $error("interrupt did not wake from stop");

    property p_bus_osc;
        busclk_src_osc |-> oscillator_qualified && pll_locked;
    endproperty
    a_bus_osc: assert property (p_bus_osc)
        else $error("bus on oscillator before qualification");

    property p_drive_len;
        $rose(reset_pin_oe_n) |-> int'(drive_cnt_q) == RST_DRIVE_CYC;
    endproperty
    a_drive_len: assert property (p_drive_len)
        else $error("reset pin drive length wrong");

    property p_sample;
        $past(rs_q) == RS_SETTLE && rs_q == RS_IDLE
            |-> ext_q == !$past(sync_q[SY_PIN]);
    endproperty
    a_sample: assert property (p_sample)
        else $error("reset origin sampled wrongly");

    property p_cm_pei;
        clock_monitor_reset |=> !oscillator_enable_q && psel_q
            && clock_mode == MODE_INT_REF;
    endproperty
    a_cm_pei: assert property (p_cm_pei)
        else $error("monitor reset did not force internal ref");

    property p_cm_stop;
        stop_active |-> !cm_fail ##1 !clock_monitor_reset;
    endproperty
    a_cm_stop: assert property (p_cm_stop)
        else $error("clock monitor active in stop");

    property p_qual_lock;
        !pll_locked |-> !oscillator_qualified;
    endproperty
    a_qual_lock: assert property (p_qual_lock)
        else $error("qualified without lock");
endmodule

/* ssr_pkg.sv */
// constants and types shared by the stop-mode and reset sequencer
// Summary of operation
// - wait keeps all clocks as run; PLL off only if software asks.
// - CPU stop instruction request is the only way into stop.
// - stop lowers regulator power, keeps periodic timer, turns off PLL and RC.
// - pseudo-stop only when pseudo-stop select and oscillator enable both set.
// - no fast wakeup, no self-clock; leaving stop takes normal recovery.
// - any interrupt request wakes the device from stop.
// - after 50 us recovery, PLL restarts and needs 150 plus 256 ref periods.
// - once relocked, PLL clock returns to its pre-stop frequency.
// - internal-ref mode: all clocks off in stop; RC reference, PLL bus.
// - external-ref mode: full stop all off; pseudo-stop keeps crystal only.
// - after full stop in bypass, bus on PLL until oscillator qualified.
// - pseudo-stop from bypass keeps crystal on, all else off.
// - any reset source drives reset pin low for 512 clock cycles.
// - wait 256 cycles after release, then sample pin for reset origin.
// - with oscillator enabled, lost or slow oscillation raises monitor reset.
// - after clock-monitor reset the device runs in internal-ref mode.
// - in stop the clock monitor is inactive; no monitor reset there.
// - losing PLL lock also clears the oscillator-qualified flag.
// - qualification lost in bypass sets PLL select, bus back to PLL.
// - reset state is internal-ref mode with post-divider 0x03.
package ssr_pkg;
    // ***************************************************
    // timing
    // ***************************************************
    localparam int CLK_MHZ          = 50;
    localparam int RECOVERY_US      = 50;
    localparam int RECOVERY_CYC     = RECOVERY_US * CLK_MHZ;
    localparam int LOCK_BASE_US     = 150;
    localparam int LOCK_REF_PERIODS = 256;
    localparam int REF_KHZ          = 1000;
    localparam int LOCK_CYC         = LOCK_BASE_US * CLK_MHZ
                                    + LOCK_REF_PERIODS * CLK_MHZ * 1000
                                      / REF_KHZ;
    localparam int CM_FAIL_KHZ      = 400;
    localparam int RST_DRIVE_CYC    = 512;
    localparam int RST_SETTLE_CYC   = 256;
    // ***************************************************
    // register map
    // ***************************************************
    localparam logic [7:0] CTRL_OFF    = 8'h00;
    localparam logic [7:0] POST_DIVIDER_SETTING_OFF = 8'h04;
    localparam logic [7:0] STATUS_OFF  = 8'h08;
    localparam int CTRL_PSEUDO_STOP_SELECT = 0;
    localparam int CTRL_OSCILLATOR_ENABLE = 1;
    localparam int CTRL_PSEL = 2;
    localparam int CTRL_WOFF = 3;
    localparam logic [3:0] CTRL_RST     = 4'h4;
    localparam logic [4:0] POST_DIVIDER_SETTING_RST  = 5'h03;
    localparam logic [4:0] POST_DIVIDER_SETTING_UNLK = 5'h03;
    localparam int ST_LOCK = 0;
    localparam int ST_QUAL = 1;
    localparam int ST_STOP = 2;
    localparam int ST_PSEUDO_STOP_SELECT = 3;
    localparam int ST_EXT  = 4;
    localparam int ST_MODE = 5;
    // ***************************************************
    // synchroniser lanes
    // ***************************************************
    localparam int SY_QUAL = 0;
    localparam int SY_PRES = 1;
    localparam int SY_SLOW = 2;
    localparam int SY_PIN  = 3;
    localparam logic [3:0] SYNC_RST = 4'hA;

    typedef enum logic [1:0] {
        SS_RUN    = 2'b00,
        SS_STOP   = 2'b01,
        SS_RECOV  = 2'b11,
        SS_RELOCK = 2'b10
    } ssr_stop_e;

    typedef enum logic [1:0] {
        RS_IDLE   = 2'b00,
        RS_DRIVE  = 2'b01,
        RS_SETTLE = 2'b11
    } ssr_rst_e;

    typedef enum logic [1:0] {
        MODE_INT_REF = 2'b00,
        MODE_EXT_REF = 2'b01,
        MODE_BYPASS  = 2'b10
    } ssr_mode_e;
endpackage

/* ssr_delay.sv */
// saturating cycle counter: done from the COUNT-th consecutive cycle that run is high
`timescale 1ns/100ps
module ssr_delay #(
    parameter int unsigned COUNT = 4
) (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic run,
    output logic      done
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    logic [W-1:0] cnt_q;

    always_ff @(posedge core_clk) begin
        if (!rstn || !run) begin
            cnt_q <= '0;
        end else if (cnt_q != LAST) begin
            cnt_q <= cnt_q + W'(1);
        end
    end

    assign done = run && (cnt_q == LAST);
endmodule

/* ssr_cpu_model.sv */
// cpu core model: stop instruction pulses and held wakeup interrupts
`timescale 1ns/100ps
module ssr_cpu_model (
    input  wire logic core_clk,
    input  wire logic rstn,
    input  wire logic go_stop,
    input  wire logic go_irq,
    input  wire logic stop_active,
    output logic      stop_req,
    output logic      irq_req
);
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            stop_req <= 1'b0;
        end else begin
            stop_req <= go_stop & ~stop_req;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq_req <= 1'b0;
        end else if (go_irq) begin
            irq_req <= 1'b1;
        end else if (!stop_active) begin
            irq_req <= 1'b0;
        end
    end
endmodule

/* tb_ssr_top.sv */
// self-checking bench for the stop-mode and reset sequencer
`timescale 1ns/100ps
module tb_ssr_top;
    import ssr_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    localparam int LK = 20;
    logic        core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, res_w = 32'h0, pd;
    logic        pready, pslverr, slv, res_v = 0, go_stop = 0, go_irq = 0;
    logic        stop_req, irq_req, wait_req = 0, reset_event = 0;
    logic        osc_qual_i = 0, osc_present_i = 1, osc_slow_i = 0;
    logic        reset_pin_i, reset_pin_o, reset_pin_oe_n, cmr_seen = 0;
    logic        sys_reset_active, reset_ext_src, clock_monitor_reset;
    logic        vreg_low_power, api_enable, pll_enable, pll_locked;
    logic        irc_enable, xosc_enable, busclk_enable, busclk_src_osc;
    logic        stop_active, pseudo_stop_active, wait_active;
    logic [1:0]  clock_mode;
    logic [11:0] obs;
    logic [4:0]  pds;
    logic        pll_reference_clock_enable, pll_reference_clock_src_osc, oq, ext_rst = 0;
    logic [4:0]  mon;
    logic [31:0] q[$];
    int          err_total = 0, num_checks = 0, cnt, cd, seed = 32'h7235;

    always #10 core_clk = ~core_clk;
    // open-drain reset pin with pull-up
    // ext_rst models a reset button pulling the pin low from outside
    assign reset_pin_i = (reset_pin_oe_n ? 1'b1 : reset_pin_o) & ~ext_rst;
    assign obs = {pll_reference_clock_enable, pll_reference_clock_src_osc, clock_mode, stop_active,
                  pseudo_stop_active, pll_enable, irc_enable, vreg_low_power,
                  busclk_enable, xosc_enable, api_enable};
    assign mon = {clock_monitor_reset, sys_reset_active, reset_pin_oe_n,
                  stop_active, pll_locked};

    ssr_top #(.LOCK_CYCLES(LK)) dut (
        .core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .stop_req, .wait_req, .irq_req,
        .reset_event, .osc_qual_i, .osc_present_i, .osc_slow_i,
        .reset_pin_i, .reset_pin_o, .reset_pin_oe_n, .sys_reset_active,
        .reset_ext_src, .clock_monitor_reset, .vreg_low_power, .api_enable,
        .pll_enable, .pll_locked, .post_divider_setting(pds), .irc_enable,
        .xosc_enable, .pll_reference_clock_enable, .pll_reference_clock_src_osc, .busclk_enable,
        .busclk_src_osc, .oscillator_qualified(oq), .clock_mode, .stop_active,
        .pseudo_stop_active, .wait_active);

    ssr_cpu_model cpu (.core_clk, .rstn, .go_stop, .go_irq, .stop_active,
                       .stop_req, .irq_req);
    // ****************************************
    // tasks
    // ****************************************
    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    always @(posedge core_clk) begin
        if (res_v === 1'b1) cmp_word(q.pop_front(), res_w);
        if (clock_monitor_reset === 1'b1) cmr_seen <= 1'b1;
    end

    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        q.push_back(e);
        res_w <= g;
        res_v <= 1'b1;
        @(posedge core_clk);
        res_v <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so a following call never reassigns psel in one step
        @(posedge core_clk);
    endtask

    task automatic wait_bit(input int i, input logic v, input int lim);
        cnt = 0;
        while (mon[i] !== v && cnt < lim) begin
            @(posedge core_clk);
            cnt++;
        end
        if (cnt >= lim) begin
            err_total++;
            $display("[ERR] %0t wait timed out", $time);
        end
    endtask

    task automatic do_stop(input logic pst, input logic oscillator_enable);
        logic       ps;
        logic [1:0] m;
        logic [31:0] e;
        ps = pst & oscillator_enable;
        m = oscillator_enable ? MODE_EXT_REF : MODE_INT_REF;
        apb(1'b1, CTRL_OFF, {29'h0, 1'b1, oscillator_enable, pst});
        go_stop <= 1'b1;
        @(posedge core_clk);
        go_stop <= 1'b0;
        wait_bit(1, 1'b1, 10);
        // monitor must stay quiet while stopped
        osc_present_i <= 1'b0;
        e = {20'h0, 1'b0, oscillator_enable, m, 1'b1, ps, 4'b0010, ps, 1'b1};
        chk(e, {20'h0, obs});
        osc_present_i <= 1'b1;
        repeat (4) @(posedge core_clk);
        go_irq <= 1'b1;
        @(posedge core_clk);
        go_irq <= 1'b0;
        wait_bit(1, 1'b0, 10);
        wait_bit(0, 1'b1, 4000);
        chk(32'h1, {31'h0, cnt >= RECOVERY_CYC + LK - 2});
        e = {15'h0, pd[4:0], 1'b1, oscillator_enable, m, 2'b00, 4'b1101, oscillator_enable, 1'b1};
        chk(e, {15'h0, pds, obs});
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (40000) @(posedge core_clk);
        err_total++;
        end_of_test;
    end

    initial begin
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        wait_bit(0, 1'b1, 100);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(32'h4, rd);
        apb(1'b0, POST_DIVIDER_SETTING_OFF, 32'h0);
        chk(32'h3, rd);
        apb(1'b0, 8'h0C, 32'h0);
        chk(32'h1, {31'h0, slv});
        pd = $random(seed);
        apb(1'b1, POST_DIVIDER_SETTING_OFF, pd);
        apb(1'b0, POST_DIVIDER_SETTING_OFF, 32'h0);
        chk({27'h0, pd[4:0]}, rd);
        wait_req <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk(32'h1835, {19'h0, wait_active, obs});
        wait_req <= 1'b0;
        for (int i = 0; i < 4; i++) do_stop(i[1], i[0]);
        osc_qual_i <= 1'b1;
        apb(1'b1, CTRL_OFF, 32'h2);
        repeat (4) @(posedge core_clk);
        chk(32'hD, {28'h0, oq, clock_mode, busclk_src_osc});
        apb(1'b1, POST_DIVIDER_SETTING_OFF, 32'h1F);
        apb(1'b0, POST_DIVIDER_SETTING_OFF, 32'h0);
        chk({27'h0, pd[4:0]}, rd);
        osc_qual_i <= 1'b0;
        repeat (4) @(posedge core_clk);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(32'h6, rd);
        chk(32'h2, {28'h0, oq, clock_mode, busclk_src_osc});
        apb(1'b1, CTRL_OFF, 32'h4);
        reset_event <= 1'b1;
        @(posedge core_clk);
        reset_event <= 1'b0;
        wait_bit(2, 1'b0, 10);
        wait_bit(2, 1'b1, 600);
        cd = cnt;
        wait_bit(3, 1'b0, 400);
        chk(32'd512, 32'(cd));
        chk(32'd256, 32'(cnt));
        chk(32'h0, {31'h0, reset_ext_src});
        chk(32'h0, {31'h0, cmr_seen});
        apb(1'b1, CTRL_OFF, 32'h6);
        osc_present_i <= 1'b0;
        wait_bit(4, 1'b1, 20);
        osc_present_i <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk({30'h0, MODE_INT_REF}, {30'h0, clock_mode});
        wait_bit(3, 1'b0, 1000);
        apb(1'b0, CTRL_OFF, 32'h0);
        chk(32'h4, rd);
        // pin held low from outside: origin external, then sequence reruns
        ext_rst <= 1'b1;
        wait_bit(3, 1'b1, 10);
        wait_bit(3, 1'b0, 1000);
        ext_rst <= 1'b0;
        chk(32'h1, {31'h0, reset_ext_src});
        wait_bit(3, 1'b0, 1000);
        chk(32'h0, {31'h0, reset_ext_src});
        end_of_test;
    end
endmodule
